// ---- spsc_pkg.sv ----
`default_nettype none
package spsc_pkg;

    // ****************************************
    // widths and counts
    // ****************************************
    localparam int         WORD_BITS  = 16;
    localparam int         DIV_W      = 8;
    localparam int         EDGE_W     = 6;
    localparam logic [5:0] EDGE_LAST  = 6'h1f;
    localparam logic [6:0] EDGE_TOTAL = 7'h20;
    localparam logic [7:0] MIN_PHASE  = 8'h01;

    // ****************************************
    // field positions and settings
    // ****************************************
    localparam int         CSTOP_EN_BIT    = 1;
    localparam int         CSTOP_DELAY_BIT = 0;
    localparam logic       SRC_CPU         = 1'b1;
    localparam logic [7:0] SLAVE_DIV       = 8'h01;
    localparam logic       DIR_OUT         = 1'b1;
    localparam logic       DIR_IN          = 1'b0;
    localparam int         SY_SCLK         = 0;
    localparam int         SY_FSX          = 1;
    localparam int         SY_FSR          = 2;
    localparam int         SY_DIN          = 3;

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic       SCLK_RESET   = 1'b1;
    localparam logic       FS_PIN_RESET = 1'b1;
    localparam logic [1:0] RST_SYNC_CLR = 2'h0;

    // ****************************************
    // states
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_SHIFT = 2'h1,
        ST_TAIL  = 2'h3
    } spsc_state_t;

endpackage
`default_nettype wire

// ---- spsc_srg.sv ----
`timescale 1ns/100ps
`default_nettype none
module spsc_srg
    import spsc_pkg::*;
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_core_n,
    // control
    input  wire logic             run,
    input  wire logic             allow,
    input  wire logic             idle_level,
    input  wire logic [DIV_W-1:0] divider,
    // generated clock
    output var  logic             level,
    output var  logic             edge_pulse,
    output var  logic             expire
);

    typedef struct packed {
        logic             level;
        logic             edge_pulse;
        logic             expire;
        logic [DIV_W-1:0] cnt;
    } spsc_srg_t;

    spsc_srg_t q;
    spsc_srg_t next_q;

    // one unit of count is one mclk cycle, i.e. 2H
    function automatic logic [DIV_W-1:0] phase_len(input logic high, input logic [DIV_W-1:0] div);
        logic [DIV_W-1:0] len;
        len = (div >> 1) + {{(DIV_W-1){1'b0}}, (div[0] | high)}; // see R03 see R04
        if (div == '0) begin
            len = MIN_PHASE; // a zero divider cannot split one cycle, so it runs as two
        end
        return len;
    endfunction

    // ****************************************
    // phase counter
    // ****************************************
    always_comb begin
        next_q = q;
        next_q.edge_pulse = 1'b0;
        next_q.expire = 1'b0;
        if (!run) begin
            next_q.level = idle_level; // see R13
            next_q.cnt = phase_len(idle_level, divider);
        end else if (q.cnt <= MIN_PHASE) begin
            next_q.expire = 1'b1;
            if (allow) begin
                next_q.level = ~q.level; // see R02
                next_q.edge_pulse = 1'b1;
                next_q.cnt = phase_len(~q.level, divider);
            end else begin
                next_q.cnt = phase_len(q.level, divider);
            end
        end else begin
            next_q.cnt = q.cnt - MIN_PHASE;
        end
    end

    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            q <= '{level: SCLK_RESET, edge_pulse: 1'b0, expire: 1'b0, cnt: MIN_PHASE};
        end else begin
            q <= next_q;
        end
    end

    assign level      = q.level;
    assign edge_pulse = q.edge_pulse;
    assign expire     = q.expire;

endmodule
`default_nettype wire

// ---- spsc_port.sv ----
// Summary of operation
// R01: slave runs only with cpu clock source and divider one, half cpu rate.
// R02: master clock period is (1 + divider) mclk cycles; divider zero gives a two-cycle period.
// R03: high phase is half period, or divider/2 + 1 cycles for even divider.
// R04: low phase is half period, or divider/2 cycles for even nonzero divider.
// R05: master drives frame sync inverted as active-low slave enable when polarities set.
// R06: slave inverts active-low enables on both frame sync pins before use.
// R07: master: tx clock and tx sync are outputs, rx clock and rx sync inputs.
// R08: slave: all four clock and sync directions are inputs.
// R09: enable goes low before the first clock edge; transfer starts on that edge.
// R10: delayed mode with polarity one samples data on the falling clock edge.
// R11: delayed mode with polarity one launches data from the rising clock edge.
// R12: data output released to high impedance after last bit, from the rising edge.
// R13: clock polarity one means the serial clock idles high between transfers.
`timescale 1ns/100ps
`default_nettype none
module spsc_port
    import spsc_pkg::*;
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // configuration
    input  wire logic                 port_enable,
    input  wire logic                 master_mode,
    input  wire logic [1:0]           clock_stop_mode_sel,
    input  wire logic                 tx_clock_polarity,
    input  wire logic                 tx_sync_polarity,
    input  wire logic                 rx_sync_polarity,
    input  wire logic                 srg_source_select,
    input  wire logic [DIV_W-1:0]     srg_divider,
    // configuration status
    output var  logic                 tx_clock_direction,
    output var  logic                 rx_clock_direction,
    output var  logic                 tx_sync_direction,
    output var  logic                 rx_sync_direction,
    output var  logic                 srg_config_ok,
    output var  logic                 sample_rate_clock,
    // serial pins
    input  wire logic                 spi_serial_clock_in,
    output var  logic                 spi_serial_clock_out,
    output var  logic                 spi_serial_clock_oe,
    input  wire logic                 tx_frame_sync_pin_in,
    output var  logic                 tx_frame_sync_pin_out,
    output var  logic                 tx_frame_sync_pin_oe,
    input  wire logic                 rx_frame_sync_pin,
    input  wire logic                 serial_data_in,
    output var  logic                 serial_data_out,
    output var  logic                 serial_data_oe,
    // user data
    input  wire logic [WORD_BITS-1:0] tx_data,
    input  wire logic                 tx_valid,
    output var  logic                 tx_taken,
    output var  logic [WORD_BITS-1:0] rx_data,
    output var  logic                 rx_valid
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        spsc_state_t          state;
        logic [3:0]           s1;
        logic [3:0]           s2;
        logic                 sclk_prev;
        logic [EDGE_W-1:0]    edge_cnt;
        logic [WORD_BITS-1:0] txsh;
        logic [WORD_BITS-1:0] rxsh;
        logic [WORD_BITS-1:0] rx_data;
        logic                 rx_valid;
        logic                 tx_taken;
        logic                 dout;
        logic                 doe;
        logic                 fs_out;
        logic                 pin_oe;
        logic                 tx_dir;
        logic                 rx_dir;
        logic                 cfg_ok;
    } spsc_port_t;

    spsc_port_t q;
    spsc_port_t next_q;

    logic [1:0] rst_sync;
    logic       rst_core_n;
    logic       srg_level;
    logic       srg_edge;
    logic       srg_expire;
    logic       srg_run;
    logic       srg_allow;
    logic       enabled;
    logic       sample_first;
    logic       sel_tx;
    logic       sel_rx;
    logic       ev_edge;
    logic       is_sample;
    logic       last_edge;

    // ****************************************
    // reset release
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= RST_SYNC_CLR;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_core_n = rst_sync[1];

    // ****************************************
    // clock generator
    // ****************************************
    // in slave mode the generator free-runs as the sample rate clock; bit edges come from the pin clock
    assign srg_run   = master_mode ? (q.state != ST_IDLE) : 1'b1; // see R01
    // count the edge still in flight so a one-cycle phase cannot overshoot
    assign srg_allow = master_mode ?
                       (({1'b0, q.edge_cnt} + {{EDGE_W{1'b0}}, srg_edge}) < EDGE_TOTAL) : 1'b1;

    spsc_srg u_srg (
        .mclk       (mclk),
        .rst_core_n (rst_core_n),
        .run        (srg_run),
        .allow      (srg_allow),
        .idle_level (tx_clock_polarity),
        .divider    (srg_divider),
        .level      (srg_level),
        .edge_pulse (srg_edge),
        .expire     (srg_expire)
    );

    // ****************************************
    // decode
    // ****************************************
    assign enabled      = port_enable & clock_stop_mode_sel[CSTOP_EN_BIT];
    assign sample_first = clock_stop_mode_sel[CSTOP_DELAY_BIT];
    assign sel_tx       = q.s2[SY_FSX] ^ tx_sync_polarity; // see R06
    assign sel_rx       = q.s2[SY_FSR] ^ rx_sync_polarity; // see R06
    assign ev_edge      = master_mode ? srg_edge : (q.s2[SY_SCLK] != q.sclk_prev);
    // even edges leave the idle level; with idle high that is the falling edge
    assign is_sample    = (~q.edge_cnt[0]) == sample_first; // see R10
    assign last_edge    = q.edge_cnt == EDGE_LAST;

    // ****************************************
    // transfer control
    // ****************************************
    always_comb begin
        next_q = q;
        next_q.rx_valid = 1'b0;
        next_q.tx_taken = 1'b0;
        next_q.s1 = {serial_data_in, rx_frame_sync_pin, tx_frame_sync_pin_in, spi_serial_clock_in};
        next_q.s2 = q.s1;
        next_q.sclk_prev = q.s2[SY_SCLK];
        next_q.cfg_ok = (srg_source_select == SRC_CPU) && (srg_divider == SLAVE_DIV); // see R01
        next_q.tx_dir = master_mode ? DIR_OUT : DIR_IN; // see R07 see R08
        next_q.rx_dir = DIR_IN; // see R07 see R08
        next_q.pin_oe = master_mode & enabled; // see R07
        if (!enabled || (!master_mode && !q.cfg_ok)) begin
            next_q.state = ST_IDLE;
            next_q.doe = 1'b0;
            next_q.fs_out = tx_sync_polarity;
        end else begin
            case (q.state)
                ST_IDLE: begin
                    next_q.edge_cnt = '0;
                    next_q.fs_out = tx_sync_polarity;
                    if (master_mode ? tx_valid : sel_tx) begin
                        next_q.state = ST_SHIFT;
                        // frame goes active one idle phase before the first edge
                        next_q.fs_out = ~tx_sync_polarity; // see R05 see R09
                        next_q.doe = 1'b1;
                        next_q.tx_taken = tx_valid;
                        next_q.txsh = tx_valid ? tx_data : '0;
                        next_q.dout = 1'b0;
                        if (sample_first) begin
                            next_q.dout = next_q.txsh[WORD_BITS-1];
                            next_q.txsh = {next_q.txsh[WORD_BITS-2:0], 1'b0};
                        end
                    end
                end
                ST_SHIFT: begin
                    if (ev_edge) begin
                        next_q.edge_cnt = q.edge_cnt + 1'b1;
                        if (is_sample) begin
                            if (master_mode || sel_rx) begin
                                next_q.rxsh = {q.rxsh[WORD_BITS-2:0], q.s2[SY_DIN]}; // see R10
                            end
                        end else if (!last_edge) begin
                            next_q.dout = q.txsh[WORD_BITS-1]; // see R11
                            next_q.txsh = {q.txsh[WORD_BITS-2:0], 1'b0};
                        end
                        if (last_edge) begin
                            next_q.doe = 1'b0; // see R12
                            next_q.rx_data = next_q.rxsh;
                            next_q.rx_valid = 1'b1;
                            next_q.state = ST_TAIL;
                        end
                    end
                end
                ST_TAIL: begin
                    // master holds the enable for one idle phase after the last edge
                    if (master_mode && srg_expire) begin
                        next_q.fs_out = tx_sync_polarity; // see R05
                        next_q.state = ST_IDLE;
                    end
                end
                default: begin
                    next_q.state = ST_IDLE;
                end
            endcase
            // a slave deselected early aborts and frees the data line at once
            if (!master_mode && !sel_tx && q.state != ST_IDLE) begin
                next_q.state = ST_IDLE;
                next_q.doe = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            // sync stages start at idle-high pin levels, so no false edge or select after reset
            q <= '{state: ST_IDLE, fs_out: FS_PIN_RESET, sclk_prev: SCLK_RESET,
                   s1: {1'b0, FS_PIN_RESET, FS_PIN_RESET, SCLK_RESET},
                   s2: {1'b0, FS_PIN_RESET, FS_PIN_RESET, SCLK_RESET}, default: '0};
        end else begin
            q <= next_q;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign tx_clock_direction    = q.tx_dir;
    assign tx_sync_direction     = q.tx_dir;
    assign rx_clock_direction    = q.rx_dir;
    assign rx_sync_direction     = q.rx_dir;
    assign srg_config_ok         = q.cfg_ok;
    assign sample_rate_clock     = srg_level;
    assign spi_serial_clock_out  = srg_level;
    assign spi_serial_clock_oe   = q.pin_oe;
    assign tx_frame_sync_pin_out = q.fs_out;
    assign tx_frame_sync_pin_oe  = q.pin_oe;
    assign serial_data_out       = q.dout;
    assign serial_data_oe        = q.doe;
    assign tx_taken              = q.tx_taken;
    assign rx_data               = q.rx_data;
    assign rx_valid              = q.rx_valid;

endmodule
`default_nettype wire

// ---- spsc_port_fix_note.sv ----
`default_nettype none
`default_nettype wire

// ---- spsc_port_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module spsc_port_monitor
    import spsc_pkg::*;
(
    // clock and reset
    input wire logic             mclk,
    input wire logic             rst_n,
    // configuration
    input wire logic             master_mode,
    input wire logic [1:0]       clock_stop_mode_sel,
    input wire logic             tx_clock_polarity,
    input wire logic             tx_sync_polarity,
    input wire logic             srg_source_select,
    input wire logic [DIV_W-1:0] srg_divider,
    // status and pins
    input wire logic             tx_clock_direction,
    input wire logic             rx_clock_direction,
    input wire logic             tx_sync_direction,
    input wire logic             rx_sync_direction,
    input wire logic             srg_config_ok,
    input wire logic             spi_serial_clock_out,
    input wire logic             spi_serial_clock_oe,
    input wire logic             tx_frame_sync_pin_out,
    input wire logic             serial_data_out,
    input wire logic             serial_data_oe
);
    logic [1:0] live;
    logic [8:0] run;
    logic       lvl;
    logic       moved;
    logic       act;
    logic       lead11;
    logic [8:0] half;
    logic [8:0] hi_len;
    logic [8:0] lo_len;
    assign act    = tx_frame_sync_pin_out != tx_sync_polarity;
    assign lead11 = master_mode && clock_stop_mode_sel == 2'h3 && tx_clock_polarity;
    // divider zero cannot give half a cycle, so it runs one cycle a phase
    assign half   = (srg_divider == 8'h00) ? 9'h001 : ({1'b0, srg_divider} + 9'h001) >> 1;
    assign hi_len = (srg_divider[0] || srg_divider == 8'h00) ? half : {2'h0, srg_divider[7:1]} + 9'h001;
    assign lo_len = (srg_divider[0] || srg_divider == 8'h00) ? half : {2'h0, srg_divider[7:1]};
    // mirrors the two-flop reset release; run counts cycles at the present level
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            live  <= 2'h0;
            run   <= 9'h001;
            lvl   <= 1'b1;
            moved <= 1'b0;
        end else begin
            live  <= {live[0], 1'b1};
            lvl   <= spi_serial_clock_out;
            run   <= (spi_serial_clock_out != lvl) ? 9'h001 : run + {8'h00, run != 9'h1ff};
            moved <= act && (moved || spi_serial_clock_out != lvl);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_dir_in;
        rx_clock_direction == DIR_IN && rx_sync_direction == DIR_IN && tx_sync_direction == tx_clock_direction;
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("receive pins not inputs");
    property p_dir_tx;
        $past(live[1]) |-> tx_clock_direction == ($past(master_mode) ? DIR_OUT : DIR_IN);
    endproperty
    a_dir_tx: assert property (p_dir_tx) else $error("transmit direction wrong");
    property p_cfg;
        $past(live[1]) |-> srg_config_ok == ($past(srg_source_select) == SRC_CPU && $past(srg_divider) == SLAVE_DIV);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config flag wrong");
    property p_idle;
        spi_serial_clock_oe && !act |-> spi_serial_clock_out == tx_clock_polarity;
    endproperty
    a_idle: assert property (p_idle) else $error("clock not at idle level");
    property p_lead;
        spi_serial_clock_oe && act && !$past(act) |-> spi_serial_clock_out == tx_clock_polarity && $past(spi_serial_clock_out) == tx_clock_polarity;
    endproperty
    a_lead: assert property (p_lead) else $error("clock moved before enable");
    property p_launch;
        lead11 && $past(serial_data_oe) && serial_data_oe && $changed(serial_data_out) |-> $past(spi_serial_clock_out) && !$past(spi_serial_clock_out, 2);
    endproperty
    a_launch: assert property (p_launch) else $error("data not launched after rise");
    property p_release;
        lead11 && $fell(serial_data_oe) |-> $past(spi_serial_clock_out) && !$past(spi_serial_clock_out, 2);
    endproperty
    a_release: assert property (p_release) else $error("data release not after rise");
    property p_high;
        spi_serial_clock_oe && moved && $fell(spi_serial_clock_out) |-> run == hi_len;
    endproperty
    a_high: assert property (p_high) else $error("high phase length wrong");
    property p_low;
        spi_serial_clock_oe && moved && $rose(spi_serial_clock_out) |-> run == lo_len;
    endproperty
    a_low: assert property (p_low) else $error("low phase length wrong");
endmodule
bind spsc_port spsc_port_monitor i_monitor (.mclk, .rst_n, .master_mode, .clock_stop_mode_sel,
    .tx_clock_polarity, .tx_sync_polarity, .srg_source_select, .srg_divider, .tx_clock_direction,
    .rx_clock_direction, .tx_sync_direction, .rx_sync_direction, .srg_config_ok,
    .spi_serial_clock_out, .spi_serial_clock_oe, .tx_frame_sync_pin_out, .serial_data_out,
    .serial_data_oe);
`default_nettype wire

// ---- spsc_peer.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// far-side peer: idle-high clock, active-low enable
// ****************************************
module spsc_peer
    import spsc_pkg::*;
#(
    parameter int PH = 6
)
(
    // clock and role, 1 = peer drives clock and enable
    input  wire logic                 mclk,
    input  wire logic                 lead_role,
    input  wire logic [WORD_BITS-1:0] word,
    // lines
    input  wire logic                 line_clk,
    input  wire logic                 line_sel_n,
    input  wire logic                 line_to_peer,
    output var  logic                 peer_clk,
    output var  logic                 peer_sel_n,
    output var  logic                 peer_data,
    output var  logic [WORD_BITS-1:0] got
);
    logic [WORD_BITS-1:0] shift;
    initial begin
        peer_clk = 1'b1;
        peer_sel_n = 1'b1;
        peer_data = 1'b0;
    end
    always @(negedge line_sel_n) if (!lead_role) begin
        shift <= word;
        peer_data <= word[WORD_BITS-1];
    end
    always @(posedge line_clk) if (!lead_role && !line_sel_n) begin
        shift <= shift << 1;
        peer_data <= shift[WORD_BITS-2];
    end
    always @(negedge line_clk) if (!lead_role && !line_sel_n) got <= {got[WORD_BITS-2:0], line_to_peer};
    // a released line shows the inverse, never the last bit
    always @(posedge line_sel_n) if (!lead_role) peer_data <= ~peer_data;
    // slow enough for the port's input synchroniser
    task automatic lead_word(input int nbits);
        shift = word;
        @(posedge mclk);
        peer_sel_n <= 1'b0;
        peer_data <= word[WORD_BITS-1];
        repeat (PH) @(posedge mclk);
        for (int i = 0; i < nbits; i++) begin
            peer_clk <= 1'b0;
            got = {got[WORD_BITS-2:0], line_to_peer};
            repeat (PH) @(posedge mclk);
            peer_clk <= 1'b1;
            shift = shift << 1;
            peer_data <= shift[WORD_BITS-1];
            repeat (PH) @(posedge mclk);
        end
        peer_sel_n <= 1'b1;
        peer_data <= ~peer_data;
        repeat (PH) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ---- serial_port_spi_clock_stop_mode_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_port_spi_clock_stop_mode_test
    import spsc_pkg::*;
;
    logic mclk, rst_n, port_enable, master_mode, tx_clock_polarity, tx_sync_polarity;
    logic rx_sync_polarity, srg_source_select, tx_valid, tx_taken, rx_valid, srg_config_ok;
    logic tx_clock_direction, rx_clock_direction, tx_sync_direction, rx_sync_direction;
    logic spi_serial_clock_out, spi_serial_clock_oe, tx_frame_sync_pin_out, tx_frame_sync_pin_oe;
    logic serial_data_out, serial_data_oe, line_clk, line_sel_n, line_to_peer;
    logic peer_clk, peer_sel_n, peer_data, sample_rate_clock;
    logic [1:0] clock_stop_mode_sel;
    logic [7:0] srg_divider;
    logic [15:0] tx_data, rx_data, peer_word, peer_got;
    logic [7:0] divs [4] = '{8'h00, 8'h01, 8'h04, 8'h05};
    logic [15:0] words [4] = '{16'h8001, 16'h7ffe, 16'ha55a, 16'h1234};
    int mismatches = 0, checked = 0, cycles = 0, rx_count = 0;
    spsc_port i_dut (.mclk, .rst_n, .port_enable, .master_mode, .clock_stop_mode_sel,
        .tx_clock_polarity, .tx_sync_polarity, .rx_sync_polarity, .srg_source_select, .srg_divider,
        .tx_clock_direction, .rx_clock_direction, .tx_sync_direction, .rx_sync_direction,
        .srg_config_ok, .sample_rate_clock, .spi_serial_clock_in(line_clk), .spi_serial_clock_out,
        .spi_serial_clock_oe, .tx_frame_sync_pin_in(line_sel_n), .tx_frame_sync_pin_out,
        .tx_frame_sync_pin_oe, .rx_frame_sync_pin(line_sel_n), .serial_data_in(peer_data),
        .serial_data_out, .serial_data_oe, .tx_data, .tx_valid, .tx_taken, .rx_data, .rx_valid);
    spsc_peer i_peer (.mclk, .lead_role(!master_mode), .word(peer_word), .line_clk, .line_sel_n,
        .line_to_peer, .peer_clk, .peer_sel_n, .peer_data, .got(peer_got));
    assign line_clk = spi_serial_clock_oe ? spi_serial_clock_out : peer_clk;
    assign line_sel_n = tx_frame_sync_pin_oe ? tx_frame_sync_pin_out : peer_sel_n;
    assign line_to_peer = serial_data_oe ? serial_data_out : ~serial_data_out;
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (rx_valid === 1'b1) rx_count++;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic master_word(input logic [7:0] div, input logic [15:0] w, input logic [15:0] pw);
        int n;
        @(posedge mclk);
        master_mode <= 1'b1;
        srg_divider <= div;
        tx_data <= w;
        peer_word <= pw;
        tx_valid <= 1'b1;
        for (n = 0; n < 50 && tx_taken !== 1'b1; n++) @(posedge mclk);
        tx_valid <= 1'b0;
        check("taken", 16'h0001, 16'(tx_taken));
        check("enable pin", 16'h0000, 16'(tx_frame_sync_pin_out));
        check("clock dir", 16'(DIR_OUT), 16'(tx_clock_direction));
        check("pin oe", 16'h0003, {14'h0000, spi_serial_clock_oe, tx_frame_sync_pin_oe});
        for (n = 0; n < 2000 && rx_valid !== 1'b1; n++) @(posedge mclk);
        check("rx valid", 16'h0001, 16'(rx_valid));
        check("data oe", 16'h0000, 16'(serial_data_oe));
        if (div >= 8'h04) check("master rx", pw, rx_data);
        for (n = 0; n < 500 && tx_frame_sync_pin_out !== 1'b1; n++) @(posedge mclk);
        check("enable end", 16'h0001, 16'(tx_frame_sync_pin_out));
        if (div >= 8'h04) check("master tx", w, peer_got);
    endtask
    task automatic slave_word(input logic [7:0] div, input int nbits, input logic [15:0] w, input logic [15:0] pw);
        int base;
        @(posedge mclk);
        master_mode <= 1'b0;
        srg_divider <= div;
        tx_data <= w;
        peer_word <= pw;
        tx_valid <= 1'b1;
        repeat (4) @(posedge mclk);
        check("clock dir", 16'(DIR_IN), 16'(tx_clock_direction));
        check("pin oe", 16'h0000, {14'h0000, spi_serial_clock_oe, tx_frame_sync_pin_oe});
        base = rx_count;
        i_peer.lead_word(nbits);
        tx_valid <= 1'b0;
        check("slave words", (nbits == 16 && div == SLAVE_DIV) ? 16'h0001 : 16'h0000, 16'(rx_count - base));
        if (nbits == 16 && div == SLAVE_DIV) begin
            check("slave rx", pw, rx_data);
            check("slave tx", w, peer_got);
        end
    endtask
    initial begin
        rst_n = 1'b0;
        port_enable = 1'b1;
        master_mode = 1'b1;
        clock_stop_mode_sel = 2'h3;
        tx_clock_polarity = 1'b1;
        tx_sync_polarity = 1'b1;
        rx_sync_polarity = 1'b1;
        srg_source_select = SRC_CPU;
        srg_divider = 8'h01;
        tx_data = 16'h0000;
        tx_valid = 1'b0;
        peer_word = 16'h0000;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        check("idle clock", 16'(tx_clock_polarity), 16'(spi_serial_clock_out));
        check("rate clock", 16'(tx_clock_polarity), 16'(sample_rate_clock));
        for (int k = 0; k < 4; k++) master_word(divs[k], words[k], ~words[k]);
        slave_word(SLAVE_DIV, 16, 16'hc3a5, 16'h5a3c);
        slave_word(SLAVE_DIV, 8, 16'h0ff0, 16'hf00f);
        slave_word(8'h02, 16, 16'h1111, 16'h2222);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        master_word(8'h05, 16'hbeef, 16'h4321);
        tally_and_finish();
    end
endmodule
`default_nettype wire
